// [inc/dcb_params.svh]
// constants of the pixel lane encoder: offsets, fields, resets, limits
// Functional notes
// - Conversion mode: odd pixel to lanes 0-3, next even pixel to 4-7.
// - First pixel after pixel_valid rises is the odd one.
// - Conversion works the same with coding enabled or disabled.
// - Mode strap: supply dual, ground single, half supply conversion.
// - Single mode turns off upper four lanes and second_link_clock.
// - Dual mode drives both link clock outputs.
// - Coding on: each lane adds inversion_flag_bit every active word.
// - Word disparity is count of ones minus count of zeros.
// - Running disparity starts within +7..-6 and saturates there.
// - Add disparity-1 if sent plain, 1-disparity if sent inverted.
// - inversion_flag_bit is 0 for plain words, 1 for inverted ones.
// - Positive running disparity: invert positive words, else plain.
// - Negative running disparity: plain for positive words, else invert.
// - Zero running disparity: always invert.
// - coding_enable_strap high enables coding, low sends uncoded.
// - Blanking control words carry inversion_flag_bit as 0.
`ifndef DCB_PARAMS_SVH
`define DCB_PARAMS_SVH
`define DCB_CTRL_OFS      8'h00
`define DCB_STAT_OFS      8'h04
`define DCB_DISP_OFS      8'h08
`define DCB_CTRL_EN_BIT   0
`define DCB_CTRL_SEED_LSB 4
`define DCB_CTRL_LOAD_BIT 8
`define DCB_EN_RST        1'h1
`define DCB_SEED_RST      4'h0
`define DCB_RD_MAX        4'h7
`define DCB_RD_MIN        4'ha
`define DCB_STRAP_GND     2'h0
`define DCB_STRAP_HALF    2'h1
`define DCB_STRAP_VCC     2'h3
`define DCB_LANE_MASK_LO  8'h0f
`define DCB_LANE_MASK_ALL 8'hff
`endif

// [inc/dcb_pkg.sv]
// types of the pixel lane encoder
package dcb_pkg;
    typedef enum logic [1:0] {DCB_SINGLE, DCB_SPLIT, DCB_DUAL} dcb_mode_e;
    typedef logic signed [3:0] dcb_rd_t;
    typedef logic [5:0]        dcb_word_t;
    typedef logic [6:0]        dcb_lane_t;
endpackage

// [inc/dcb_lane_if.sv]
// carrier between the top and one lane coder
`timescale 1ns/1ps
`default_nettype none
interface dcb_lane_if;
    import dcb_pkg::*;
    logic      load;
    logic      active;
    logic      code_en;
    logic      seed_load;
    dcb_rd_t   seed;
    dcb_word_t data;
    dcb_lane_t word;
    dcb_rd_t   rd;
    modport ctl
    (
        output load, active, code_en, seed_load, seed, data,
        input  word, rd
    );
    modport lane
    (
        input  load, active, code_en, seed_load, seed, data,
        output word, rd
    );
endinterface
`default_nettype wire

// [hw/dcb_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dcb_sync #(parameter int W = 1)
(
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    import dcb_pkg::*;
    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dcb_sync_s;
    dcb_sync_s st_r;
    dcb_sync_s st_nxt;
    always_comb
    begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign q = st_r.s2;
endmodule
`default_nettype wire

// [hw/dcb_lane_enc.sv]
// running disparity coder of one data lane
`timescale 1ns/1ps
`default_nettype none
`include "dcb_params.svh"
module dcb_lane_enc
(
    input  wire logic  mclk,
    input  wire logic  rst,
    dcb_lane_if.lane   lp
);
    import dcb_pkg::*;
    typedef struct packed
    {
        dcb_rd_t   rd;
        dcb_lane_t word;
    } dcb_lane_s;
    dcb_lane_s          st_r;
    dcb_lane_s          st_nxt;
    logic [2:0]         ones;
    logic signed [4:0]  dd;
    logic signed [4:0]  delta;
    logic signed [5:0]  sum;
    logic               inv;
    always_comb
    begin
        ones = 3'h0;
        for (int i = 0; i < 6; i++)
            ones = ones + {2'h0, lp.data[i]};
        dd = $signed({1'b0, ones, 1'b0}) - 5'sh6;
        if (st_r.rd > 0)
            inv = dd > 0;
        else if (st_r.rd < 0)
            inv = !(dd > 0);
        else
            inv = 1'b1;
        delta = inv ? 5'sh1 - dd : dd - 5'sh1;
        sum = {{2{st_r.rd[3]}}, st_r.rd} + {delta[4], delta};
        st_nxt = st_r;
        if (lp.seed_load)
        begin
            st_nxt.rd = (lp.seed < $signed(`DCB_RD_MIN)) ? `DCB_RD_MIN
                                                         : lp.seed;
        end
        else if (lp.load && lp.active && lp.code_en)
        begin
            st_nxt.word = {inv, inv ? ~lp.data : lp.data};
            if (sum > $signed({2'h0, `DCB_RD_MAX}))
                st_nxt.rd = `DCB_RD_MAX;
            else if (sum < $signed({2'h3, `DCB_RD_MIN}))
                st_nxt.rd = `DCB_RD_MIN;
            else
                st_nxt.rd = sum[3:0];
        end
        else if (lp.load)
            st_nxt.word = {1'b0, lp.data};
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
            st_r <= {`DCB_SEED_RST, 7'h00};
        else
            st_r <= st_nxt;
    end
    assign lp.word = st_r.word;
    assign lp.rd   = st_r.rd;
endmodule
`default_nettype wire

// [hw/dcb_pixel_lane_tx.sv]
// top of the pixel lane encoder: apb slave, pixel split, lane coders
`timescale 1ns/1ps
`default_nettype none
`include "dcb_params.svh"
module dcb_pixel_lane_tx
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        pixel_clock,
    input  wire logic        pixel_valid,
    input  wire logic        hsync,
    input  wire logic        vsync,
    input  wire logic [23:0] pix_first,
    input  wire logic [23:0] pix_second,
    input  wire logic [1:0]  pixel_mode_strap,
    input  wire logic        valid_polarity_strap,
    input  wire logic        coding_enable_strap,
    output var  logic [55:0] lane_word,
    output var  logic [7:0]  lane_enable,
    output var  logic        lane_strobe,
    output var  logic        link_clock,
    output var  logic        second_link_clock
);
    import dcb_pkg::*;

    typedef struct packed
    {
        logic        en;
        logic [3:0]  seed;
        logic        seed_load;
        logic        pclk_d;
        logic        valid_d;
        logic        phase;
        logic [23:0] odd;
        logic        odd_act;
        logic        lclk1;
        logic        lclk2;
        logic [7:0]  lane_en;
        logic        strobe;
        logic [31:0] prdata;
    } dcb_top_s;

    dcb_top_s    st_r;
    dcb_top_s    st_nxt;
    logic [55:0] sync_in;
    logic [55:0] sync_q;
    logic        pclk_s;
    logic        valid_raw;
    logic        hs_s;
    logic        vs_s;
    logic [23:0] lo_s;
    logic [23:0] hi_s;
    logic [1:0]  strap_s;
    logic        pol_s;
    logic        code_s;
    dcb_mode_e   mode;
    logic        act;
    logic        pedge;
    logic        split;
    logic        vrise;
    logic        load;
    logic        act_lo;
    logic        act_hi;
    logic [23:0] ctrl_word;
    logic [23:0] lo_src;
    logic [23:0] hi_src;
    logic [31:0] rd_all;
    logic        setup;
    logic        access;
    logic        hit;
    logic [31:0] rmux;

    // pixel and strap pin inputs pass two flip-flops
    assign sync_in = {pixel_clock, pixel_valid, hsync, vsync, pix_first,
                      pix_second, pixel_mode_strap, valid_polarity_strap,
                      coding_enable_strap};

    dcb_sync #(.W(56)) u_sync
    (
        .mclk (mclk),
        .rst  (rst),
        .d    (sync_in),
        .q    (sync_q)
    );

    assign {pclk_s, valid_raw, hs_s, vs_s, lo_s, hi_s, strap_s, pol_s,
            code_s} = sync_q;

    always_comb
    begin
        case (strap_s)
            `DCB_STRAP_VCC:  mode = DCB_DUAL;
            `DCB_STRAP_HALF: mode = DCB_SPLIT;
            `DCB_STRAP_GND:  mode = DCB_SINGLE;
            default:         mode = DCB_SINGLE;
        endcase
    end

    // active level follows the polarity strap
    assign act   = (valid_raw == pol_s);
    assign pedge = pclk_s & ~st_r.pclk_d;
    assign split = (mode == DCB_SPLIT);
    assign vrise = act & ~st_r.valid_d;

    // pair leaves on the even pixel
    assign load  = pedge & (~split | (st_r.phase & ~vrise));

    // blanking carries the syncs on lane 0
    assign ctrl_word = {22'h000000, vs_s, hs_s};

    always_comb
    begin
        act_lo = 1'b0;
        act_hi = 1'b0;
        lo_src = 24'h000000;
        hi_src = 24'h000000;
        if (st_r.en)
        begin
            case (mode)
                DCB_SPLIT:
                begin
                    // odd to lanes 0-3, even to 4-7
                    act_lo = st_r.odd_act;
                    act_hi = act;
                    lo_src = st_r.odd_act ? st_r.odd : ctrl_word;
                    hi_src = act ? lo_s : 24'h000000;
                end
                DCB_DUAL:
                begin
                    act_lo = act;
                    act_hi = act;
                    lo_src = act ? lo_s : ctrl_word;
                    hi_src = act ? hi_s : 24'h000000;
                end
                DCB_SINGLE:
                begin
                    act_lo = act;
                    lo_src = act ? lo_s : ctrl_word;
                end
                default:
                begin
                    act_lo = 1'b0;
                end
            endcase
        end
    end

    dcb_lane_if lif[8] ();

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_lane
            assign lif[g].load      = load;
            assign lif[g].code_en   = code_s;
            assign lif[g].seed_load = st_r.seed_load;
            assign lif[g].seed      = st_r.seed;
            if (g < 4)
            begin : g_lo
                assign lif[g].active = act_lo;
                assign lif[g].data   = lo_src[g*6 +: 6];
            end
            else
            begin : g_hi
                assign lif[g].active = act_hi;
                assign lif[g].data   = hi_src[(g-4)*6 +: 6];
            end
            dcb_lane_enc u_enc
            (
                .mclk (mclk),
                .rst  (rst),
                .lp   (lif[g])
            );
            assign lane_word[g*7 +: 7] = lif[g].word;
            assign rd_all[g*4 +: 4]    = lif[g].rd;
        end
    endgenerate

    // apb decode, zero wait states
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign hit    = (paddr == `DCB_CTRL_OFS) | (paddr == `DCB_STAT_OFS) |
                    (paddr == `DCB_DISP_OFS);
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;

    always_comb
    begin
        case (paddr)
            `DCB_CTRL_OFS: rmux = {24'h000000, st_r.seed, 3'h0, st_r.en};
            `DCB_STAT_OFS: rmux = {24'h000000, 2'h0, st_r.en, st_r.phase,
                                   pol_s, code_s, mode};
            `DCB_DISP_OFS: rmux = rd_all;
            default:       rmux = 32'h00000000;
        endcase
    end

    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.seed_load = 1'b0;
        st_nxt.pclk_d    = pclk_s;
        st_nxt.strobe    = load;
        if (setup && !pwrite)
            st_nxt.prdata = rmux;
        if (access && pwrite && paddr == `DCB_CTRL_OFS)
        begin
            st_nxt.en        = pwdata[`DCB_CTRL_EN_BIT];
            st_nxt.seed      = pwdata[`DCB_CTRL_SEED_LSB +: 4];
            st_nxt.seed_load = pwdata[`DCB_CTRL_LOAD_BIT];
        end
        if (pedge)
        begin
            st_nxt.valid_d = act;
            if (split && (vrise || !st_r.phase))
            begin
                st_nxt.odd     = lo_s;
                st_nxt.odd_act = act;
                st_nxt.phase   = 1'b1;
            end
            else
                st_nxt.phase = 1'b0;
        end
        // link clock halves in conversion mode
        if (!st_r.en)
            st_nxt.lclk1 = 1'b0;
        else if (!split)
            st_nxt.lclk1 = pclk_s;
        else if (pedge)
            st_nxt.lclk1 = vrise | ~st_r.phase;
        // second clock only beyond single mode
        st_nxt.lclk2 = (mode != DCB_SINGLE) & st_nxt.lclk1;
        if (!st_r.en)
            st_nxt.lane_en = 8'h00;
        else if (mode == DCB_SINGLE)
            st_nxt.lane_en = `DCB_LANE_MASK_LO;
        else
            st_nxt.lane_en = `DCB_LANE_MASK_ALL;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_r      <= '0;
            st_r.en   <= `DCB_EN_RST;
            st_r.seed <= `DCB_SEED_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign prdata            = st_r.prdata;
    assign lane_enable       = st_r.lane_en;
    assign lane_strobe       = st_r.strobe;
    assign link_clock        = st_r.lclk1;
    assign second_link_clock = st_r.lclk2;

    // checks on lane 0, the split path, single-mode lane enables and link clocks in single and dual mode
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic d0_pos;
    assign d0_pos = $countones(lif[0].data) > 3;

    sequence s_coded0;
        lif[0].load && lif[0].active && lif[0].code_en &&
        !lif[0].seed_load;
    endsequence

    sequence s_pair;
        split && load && st_r.en && st_r.odd_act && act;
    endsequence

    single_off_a: assert property
        (mode == DCB_SINGLE |=> lane_enable[7:4] == 4'h0 &&
                                !second_link_clock)
        else $error("upper lanes live in single mode");

    dual_clock_a: assert property
        (mode == DCB_DUAL && $past(mode) == DCB_DUAL |->
         second_link_clock == link_clock)
        else $error("second link clock differs in dual mode");

    odd_first_a: assert property
        (split && pedge && vrise |=> st_r.phase &&
                                     st_r.odd == $past(lo_s))
        else $error("first valid pixel not held as odd");

    pair_route_a: assert property
        (s_pair |-> lif[0].data == st_r.odd[5:0] &&
                    lif[4].data == lo_s[5:0])
        else $error("odd or even pixel on wrong lanes");

    rd_range_a: assert property
        (lif[0].rd <= $signed(`DCB_RD_MAX) &&
         lif[0].rd >= $signed(`DCB_RD_MIN))
        else $error("running disparity out of range");

    flag_inv_a: assert property
        (s_coded0 |=> lif[0].word[5:0] ==
                      ($past(lif[0].data) ^ {6{lif[0].word[6]}}))
        else $error("flag does not match inversion");

    zero_rd_a: assert property
        (s_coded0 and lif[0].rd == 0 |=> lif[0].word[6])
        else $error("zero disparity word not inverted");

    pos_rd_a: assert property
        (s_coded0 and lif[0].rd > 0 |=> lif[0].word[6] == $past(d0_pos))
        else $error("wrong choice at positive disparity");

    neg_rd_a: assert property
        (s_coded0 and lif[0].rd < 0 |=> lif[0].word[6] == !$past(d0_pos))
        else $error("wrong choice at negative disparity");

    blank_flag_a: assert property
        (lif[0].load && (!lif[0].active || !lif[0].code_en) |=>
         !lif[0].word[6])
        else $error("flag set on control or uncoded word");

    rd_hold_a: assert property
        ((!lif[0].load || !lif[0].active) && !lif[0].seed_load |=>
         $stable(lif[0].rd))
        else $error("disparity moved outside active data");

endmodule
`default_nettype wire

// [tb/dcb_rx_model.sv]
// far-side receiver model: undoes lane inversion
`timescale 1ns/1ps
`default_nettype none
module dcb_rx_model
(
    input  wire logic        code_en,
    input  wire logic [55:0] lane_word,
    output var  logic [47:0] rx_pix
);
    // strap follows sender, flag restores all bits
    always_comb
    begin
        for (int g = 0; g < 8; g++)
        begin
            rx_pix[6*g+:6] = (code_en && lane_word[7*g+6]) ?
                ~lane_word[7*g+:6] : lane_word[7*g+:6];
        end
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the pixel lane encoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dcb_pkg::*;
    logic        mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, pready, pslverr, rerr;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat, ev;
    logic        pixel_clock = 1'h0, pixel_valid = 1'h0;
    logic        hsync = 1'h0, vsync = 1'h0, pc_q = 1'h0;
    logic [23:0] pix_first = 24'h0, pix_second = 24'h0, odd_px;
    logic [1:0]  pixel_mode_strap = 2'h3;
    logic        valid_polarity_strap = 1'h1, coding_enable_strap = 1'h1;
    logic [55:0] lane_word, exp_w, exp_m;
    logic [7:0]  lane_enable;
    logic        lane_strobe, link_clock, second_link_clock;
    logic [47:0] rx_pix, exp_p;
    logic [31:0] rnd = 32'h5f551ab1;
    int          rdv[8], fail_count = 0, n_checks = 0, cycles = 0;
    int          kind = 2, settle = 2, left = 2, mode = 2, second_link_clock_n = 0;
    int          lc_n = 0, pc_n = 0;
    logic [1:0]  pdiv = 2'h0;
    bit          have_odd, pend, act, run, pv_d, off;

    dcb_pixel_lane_tx dcb_pixel_lane_tx_i
    (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pixel_clock, .pixel_valid, .hsync, .vsync,
        .pix_first, .pix_second, .pixel_mode_strap, .valid_polarity_strap,
        .coding_enable_strap, .lane_word, .lane_enable, .lane_strobe,
        .link_clock, .second_link_clock
    );
    dcb_rx_model dcb_rx_model_i
    (
        .code_en   (coding_enable_strap),
        .lane_word (lane_word),
        .rx_pix    (rx_pix)
    );

    always #50 mclk = ~mclk;
    // pixel pin toggles every fourth mclk edge: 800 ns period
    always @(posedge mclk)
    begin
        pdiv <= pdiv + 2'h1;
        if (pdiv == 2'h3)
            pixel_clock <= ~pixel_clock;
    end

    always @(posedge second_link_clock) second_link_clock_n++;
    always @(posedge link_clock) lc_n++;
    always @(posedge pixel_clock) pc_n++;

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    function automatic logic [6:0] enc(input logic [5:0] d, input bit on,
                                       inout int rd);
        int ds;
        bit inv;
        ds = 2 * $countones(d) - 6;
        inv = rd == 0 || (rd > 0 && ds > 0) || (rd < 0 && ds <= 0);
        if (!on)
            return {1'h0, d};
        rd = inv ? rd + 1 - ds : rd + ds - 1;
        rd = rd > 7 ? 7 : (rd < -6 ? -6 : rd);
        return inv ? {1'h1, ~d} : {1'h0, d};
    endfunction

    task automatic check(input string nm, input logic [55:0] seen,
                         input logic [55:0] want);
        n_checks++;
        if (seen !== want)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, want, seen);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50)
            fail_count++;
        @(posedge mclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e, input string nm);
        apb(1'h0, a, 32'h0);
        check(nm, {24'h0, rdat & m}, {24'h0, e});
    endtask

    task automatic pixel_edge;
        logic [23:0] a;
        logic [23:0] b;
        if (settle > 0)
        begin
            settle--;
            kind = 2;
            return;
        end
        if (pend)
            check("word count", 56'h0, 56'h1);
        act = pixel_valid === 1'h1;
        kind = 1;
        exp_m = mode == 0 ? 56'h0fffffff : '1;
        exp_w = {54'h0, vsync, hsync};
        // odd pixel held for the pair
        if (act && mode == 1 && !have_odd)
        begin
            odd_px = pix_first;
            have_odd = 1;
            kind = 0;
        end
        else if (act)
        begin
            a = mode == 1 ? odd_px : pix_first;
            b = mode == 1 ? pix_first : pix_second;
            have_odd = 0;
            exp_p = {b, a};
            for (int g = 0; g < 8; g++)
                exp_w[7*g+:7] = enc(exp_p[6*g+:6],
                    coding_enable_strap && (g < 4 || mode != 0), rdv[g]);
        end
        else
        begin
            have_odd = 0;
            if (mode == 1)
                kind = 2;
        end
        pend = kind == 1;
    endtask

    task automatic pixel_next;
        rnd = xs(rnd);
        // valid high marks data, even blanking
        if (left == 0)
        begin
            pv_d = run && !pv_d;
            left = 2 + 2 * int'(rnd[1:0]);
            pixel_valid <= pv_d;
        end
        left--;
        pix_first <= rnd[30] ? rnd[23:0] : {24{rnd[29]}};
        hsync <= rnd[5];
        vsync <= rnd[9];
        rnd = xs(rnd);
        pix_second <= rnd[30] ? rnd[23:0] : {24{rnd[29]}};
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            kind = 2;
            settle = 2;
            pend = 0;
            pv_d = 0;
            left = 2;
            have_odd = 0;
            pixel_valid <= 1'h0;
        end
        else if (pixel_clock && !pc_q)
            pixel_edge();
        else if (!pixel_clock && pc_q)
            pixel_next();
        pc_q = pixel_clock;
    end

    always @(negedge mclk)
    begin
        if (!rst && lane_strobe === 1'h1 && kind != 2)
        begin
            if (off)
            begin
                check("off word", lane_word, 56'h0);
                check("off pins", {46'h0, lane_enable, link_clock,
                      second_link_clock}, 56'h0);
            end
            else
            begin
                check("odd word", {55'h0, kind == 0}, 56'h0);
                check("lane word", lane_word & exp_m, exp_w & exp_m);
                if (act)
                    check("decoded", {32'h0, rx_pix[23:0]},
                          {32'h0, exp_p[23:0]});
                if (act && mode != 0)
                    check("decoded upper", {32'h0, rx_pix[47:24]},
                          {32'h0, exp_p[47:24]});
                check("lanes on", {48'h0, lane_enable},
                      mode == 0 ? 56'h0f : 56'hff);
                check("clock two", {55'h0, second_link_clock},
                      {55'h0, mode != 0 && link_clock});
            end
            pend = 0;
            kind = 0;
        end
    end

    initial
    begin
        for (int ph = 0; ph < 5; ph++)
        begin
            pixel_mode_strap <= ph < 2 ? 2'h3 : (ph < 4 ? 2'h1 : 2'h0);
            coding_enable_strap <= ph % 2 == 0;
            mode = ph < 2 ? 2 : (ph < 4 ? 1 : 0);
            rst <= 1'h1;
            run = 0;
            repeat (4) @(posedge mclk);
            rst <= 1'h0;
            for (int g = 0; g < 8; g++)
                rdv[g] = 0;
            repeat (6) @(posedge mclk);
            second_link_clock_n = 0;
            lc_n = 0;
            pc_n = 0;
            if (ph == 0)
            begin
                rd_chk(8'h00, '1, 32'h1, "control");
                apb(1'h0, 8'h0c, 32'h0);
                check("unmapped", {23'h0, rerr, rdat},
                      {23'h0, 1'h1, 32'h0});
            end
            if (ph < 2)
            begin
                apb(1'h1, 8'h00, ph == 0 ? 32'h181 : 32'h171);
                for (int g = 0; g < 8; g++)
                    rdv[g] = ph == 0 ? -6 : 7;
                rd_chk(8'h08, '1, ph == 0 ? 32'haaaaaaaa : 32'h77777777,
                       "seeded");
            end
            run = 1;
            repeat (600) @(posedge mclk);
            run = 0;
            repeat (120) @(posedge mclk);
            rd_chk(8'h04, 32'hffffffef,
                   32'h28 + (ph % 2 == 0 ? 32'h4 : 32'h0) + mode,
                   "status");
            for (int g = 0; g < 8; g++)
                ev[4*g+:4] = rdv[g][3:0];
            rd_chk(8'h08, mode == 0 ? 32'hffff : '1, ev, "disparity");
            check("clock two runs", {55'h0, second_link_clock_n > 0},
                  {55'h0, mode != 0});
            // conversion halves the link clock, other modes follow pixels
            check("link clock rate",
                  {55'h0, (mode == 1 ? 2 * lc_n : lc_n) - pc_n <= 4 &&
                   pc_n - (mode == 1 ? 2 * lc_n : lc_n) <= 4},
                  56'h1);
        end
        // enable cleared: lanes, enables and clocks go quiet, rd kept
        apb(1'h1, 8'h00, 32'h0);
        off = 1;
        repeat (40) @(posedge mclk);
        rd_chk(8'h08, 32'hffff, ev, "disparity off");
        test_done();
    end
endmodule
`default_nettype wire
